// ---- fpes_host_ctrl.sv ----
// host controller sequencing commands and status polling of a boot-block flash
module fpes_host_ctrl (
   input wire logic ref_clk, // system clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic cmd_valid, // operation request
   input wire logic [3:0] cmd_op, // operation code
   input wire logic [16:0] cmd_addr, // word address or block address
   input wire logic [15:0] cmd_wdata, // program data
   output logic cmd_ready, // ready for a request
   output logic rsp_valid, // one-cycle completion pulse
   output logic rsp_error, // operation failed or refused
   output logic [15:0] rsp_rdata, // read or final poll data
   output logic [16:0] flash_addr, // address pins
   output logic [15:0] flash_dq_out, // data pins, driven value
   output logic flash_dq_oe_n, // low while driving data pins
   input wire logic [15:0] flash_dq_in, // data pins, sensed value
   output logic flash_ce_n, // chip enable, active low
   output logic flash_oe_n, // output enable, active low
   output logic flash_we_n // write enable, active low
);

   fpes_pkg::fpes_regs_t r;
   fpes_pkg::fpes_regs_t nx;
   fpes_pkg::fpes_step_t s;
   logic [15:0] dq_sync;

   // ------------------------------------------------------------
   // data pin synchroniser
   // ------------------------------------------------------------
   fpes_pin_sync #(.WIDTH(16)) u_sync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .pin(flash_dq_in),
      .q(dq_sync)
   );

   // ------------------------------------------------------------
   // command sequences
   // ------------------------------------------------------------
   function automatic fpes_pkg::fpes_step_t wr_step(logic [16:0] a, logic [15:0] d);
      fpes_pkg::fpes_step_t t;
      t.valid = 1'b1;
      t.wr = 1'b1;
      t.a = a;
      t.d = d;
      return t;
   endfunction : wr_step

   // unlock pair at idx 0/1 and 3/4, command word at idx 2
   function automatic fpes_pkg::fpes_step_t unlock_step(logic [2:0] idx, logic [15:0] d);
      fpes_pkg::fpes_step_t t;
      case (idx)
         3'h0, 3'h3: t = wr_step(fpes_pkg::UNLOCK1_ADDR, fpes_pkg::UNLOCK1_DATA);
         3'h1, 3'h4: t = wr_step(fpes_pkg::UNLOCK2_ADDR, fpes_pkg::UNLOCK2_DATA);
         default: t = wr_step(fpes_pkg::UNLOCK1_ADDR, d);
      endcase
      return t;
   endfunction : unlock_step

   function automatic fpes_pkg::fpes_step_t seq_step(logic [3:0] op, logic [2:0] idx,
                                                     logic [16:0] a, logic [15:0] d);
      fpes_pkg::fpes_step_t t;
      t = '0;
      case (op)
         fpes_pkg::OP_READ: begin
            if (idx == 3'h0) begin
               t = '{valid: 1'b1, wr: 1'b0, a: a, d: 16'h0000};
            end
         end
         fpes_pkg::OP_RESET: begin
            if (idx == 3'h0) begin
               t = wr_step(a, fpes_pkg::CMD_RESET);
            end
         end
         fpes_pkg::OP_AUTOSEL: begin
            if (idx < 3'h3) begin
               t = unlock_step(idx, fpes_pkg::CMD_AUTOSEL);
            end
         end
         fpes_pkg::OP_PROGRAM: begin
            if (idx < 3'h3) begin
               t = unlock_step(idx, fpes_pkg::CMD_PROGRAM);
            end else if (idx == 3'h3) begin
               t = wr_step(a, d);
            end
         end
         fpes_pkg::OP_BLOCK_ERASE, fpes_pkg::OP_CHIP_ERASE: begin
            if (idx < 3'h3) begin
               t = unlock_step(idx, fpes_pkg::CMD_ERASE_SETUP);
            end else if (idx < 3'h5) begin
               t = unlock_step(idx, fpes_pkg::CMD_ERASE_SETUP);
            end else if (idx == 3'h5 && op == fpes_pkg::OP_BLOCK_ERASE) begin
               t = wr_step(a, fpes_pkg::CMD_BLOCK_CONFIRM);
            end else if (idx == 3'h5) begin
               t = wr_step(fpes_pkg::UNLOCK1_ADDR, fpes_pkg::CMD_CHIP_CONFIRM);
            end
         end
         fpes_pkg::OP_ERASE_ADD: begin
            // status read first, confirm only while the timer bit is low
            if (idx == 3'h0) begin
               t = '{valid: 1'b1, wr: 1'b0, a: a, d: 16'h0000};
            end else if (idx == 3'h1) begin
               t = wr_step(a, fpes_pkg::CMD_BLOCK_CONFIRM);
            end
         end
         fpes_pkg::OP_SUSPEND: begin
            if (idx == 3'h0) begin
               t = wr_step(a, fpes_pkg::CMD_SUSPEND);
            end
         end
         fpes_pkg::OP_RESUME: begin
            if (idx == 3'h0) begin
               t = wr_step(a, fpes_pkg::CMD_RESUME);
            end
         end
         default: t = '0;
      endcase
      return t;
   endfunction : seq_step

   function automatic logic needs_poll(logic [3:0] op);
      return op == fpes_pkg::OP_PROGRAM || op == fpes_pkg::OP_CHIP_ERASE ||
             op == fpes_pkg::OP_SUSPEND || op == fpes_pkg::OP_POLL;
   endfunction : needs_poll

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      nx = r;
      s = seq_step(r.op, r.step, r.addr_q, r.wdata_q);
      nx.rsp_valid = 1'b0;
      if (r.cnt != 11'h000) begin
         nx.cnt = r.cnt - 11'h001;
      end
      case (r.st)
         fpes_pkg::ST_IDLE: begin
            nx.cmd_ready = 1'b1;
            if (cmd_valid && r.cmd_ready) begin
               nx.cmd_ready = 1'b0;
               nx.op = cmd_op;
               nx.addr_q = cmd_addr;
               nx.wdata_q = cmd_wdata;
               nx.step = 3'h0;
               nx.in_poll = 1'b0;
               nx.poll_n = 2'h0;
               nx.err_pend = 1'b0;
               nx.rsp_error = 1'b0;
               nx.st = fpes_pkg::ST_NEXT;
            end
         end
         fpes_pkg::ST_NEXT: begin
            if (s.valid) begin
               nx.f_addr = s.a;
               nx.f_dq = s.d;
               nx.f_ce_n = 1'b0;
               if (s.wr) begin
                  nx.f_dq_oe_n = 1'b0;
                  nx.cnt = fpes_pkg::WR_SETUP_CYC - 11'h001;
                  nx.st = fpes_pkg::ST_WR_SETUP;
               end else begin
                  nx.f_oe_n = 1'b0;
                  nx.cnt = fpes_pkg::RD_CYC - 11'h001;
                  nx.st = fpes_pkg::ST_RD_ACT;
               end
            end else if (r.op > fpes_pkg::OP_POLL) begin
               nx.rsp_error = 1'b1;
               nx.st = fpes_pkg::ST_RESP;
            end else if (needs_poll(r.op)) begin
               // polling starts only after the final command strobe
               nx.busy = r.busy | (r.op != fpes_pkg::OP_POLL);
               nx.in_poll = 1'b1;
               nx.f_addr = r.addr_q;
               nx.f_ce_n = 1'b0;
               nx.f_oe_n = 1'b0;
               nx.cnt = fpes_pkg::RD_CYC - 11'h001;
               nx.st = fpes_pkg::ST_RD_ACT;
            end else if (r.op == fpes_pkg::OP_RESET && r.busy) begin
               nx.busy = 1'b0;
               nx.cnt = fpes_pkg::RECOVER_CYC - 11'h001;
               nx.st = fpes_pkg::ST_RECOVER;
            end else begin
               if (r.op == fpes_pkg::OP_BLOCK_ERASE) begin
                  nx.busy = 1'b1;
               end
               nx.st = fpes_pkg::ST_RESP;
            end
         end
         fpes_pkg::ST_WR_SETUP: begin
            if (r.cnt == 11'h000) begin
               nx.f_we_n = 1'b0;
               nx.cnt = fpes_pkg::WE_PULSE_CYC - 11'h001;
               nx.st = fpes_pkg::ST_WR_PULSE;
            end
         end
         fpes_pkg::ST_WR_PULSE: begin
            if (r.cnt == 11'h000) begin
               nx.f_we_n = 1'b1;
               nx.cnt = fpes_pkg::WR_HOLD_CYC - 11'h001;
               nx.st = fpes_pkg::ST_WR_HOLD;
            end
         end
         fpes_pkg::ST_WR_HOLD: begin
            if (r.cnt == 11'h000) begin
               nx.f_ce_n = 1'b1;
               nx.f_dq_oe_n = 1'b1;
               nx.step = r.step + 3'h1;
               nx.st = fpes_pkg::ST_NEXT;
            end
         end
         fpes_pkg::ST_RD_ACT: begin
            // each read ends with a strobe release so the toggle bit steps
            if (r.cnt == 11'h000) begin
               nx.rd = dq_sync;
               nx.f_oe_n = 1'b1;
               nx.f_ce_n = 1'b1;
               nx.cnt = fpes_pkg::RD_GAP_CYC - 11'h001;
               nx.st = fpes_pkg::ST_RD_GAP;
            end
         end
         fpes_pkg::ST_RD_GAP: begin
            if (r.cnt == 11'h000) begin
               nx.rsp_rdata = r.rd;
               if (r.in_poll) begin
                  nx.st = fpes_pkg::ST_POLL_EVAL;
               end else if (r.op == fpes_pkg::OP_ERASE_ADD && r.step == 3'h0 &&
                            r.rd[fpes_pkg::ERASE_TIMER_BIT]) begin
                  nx.rsp_error = 1'b1;
                  nx.st = fpes_pkg::ST_RESP;
               end else begin
                  nx.step = r.step + 3'h1;
                  nx.st = fpes_pkg::ST_NEXT;
               end
            end
         end
         fpes_pkg::ST_POLL_EVAL: begin
            nx.f_ce_n = 1'b0;
            nx.f_oe_n = 1'b0;
            nx.cnt = fpes_pkg::RD_CYC - 11'h001;
            nx.st = fpes_pkg::ST_RD_ACT;
            case (r.poll_n)
               2'h0: begin
                  nx.prev = r.rd[7:0];
                  nx.poll_n = 2'h1;
               end
               2'h1: begin
                  if (r.rd[fpes_pkg::PRIMARY_TOGGLE_BIT] == r.prev[fpes_pkg::PRIMARY_TOGGLE_BIT]) begin
                     nx.poll_n = 2'h3;
                  end else if (r.rd[fpes_pkg::ERROR_FLAG_BIT] && r.err_pend) begin
                     nx.rsp_error = 1'b1;
                     nx.f_ce_n = 1'b1;
                     nx.f_oe_n = 1'b1;
                     nx.st = fpes_pkg::ST_RESP;
                  end else if (r.rd[fpes_pkg::ERROR_FLAG_BIT]) begin
                     nx.err_pend = 1'b1;
                     nx.poll_n = 2'h0;
                  end else begin
                     nx.prev = r.rd[7:0];
                  end
               end
               default: begin
                  // final read after the toggle settled carries the result
                  nx.f_ce_n = 1'b1;
                  nx.f_oe_n = 1'b1;
                  if (r.op != fpes_pkg::OP_SUSPEND) begin
                     nx.busy = 1'b0;
                  end
                  nx.st = fpes_pkg::ST_RESP;
               end
            endcase
         end
         fpes_pkg::ST_RECOVER: begin
            if (r.cnt == 11'h000) begin
               nx.st = fpes_pkg::ST_RESP;
            end
         end
         fpes_pkg::ST_RESP: begin
            nx.rsp_valid = 1'b1;
            nx.cmd_ready = 1'b1;
            nx.st = fpes_pkg::ST_IDLE;
         end
         default: nx.st = fpes_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         r.f_dq_oe_n <= 1'b1;
         r.f_ce_n <= 1'b1;
         r.f_oe_n <= 1'b1;
         r.f_we_n <= 1'b1;
      end else begin
         r <= nx;
      end
   end

   assign cmd_ready = r.cmd_ready;
   assign rsp_valid = r.rsp_valid;
   assign rsp_error = r.rsp_error;
   assign rsp_rdata = r.rsp_rdata;
   assign flash_addr = r.f_addr;
   assign flash_dq_out = r.f_dq;
   assign flash_dq_oe_n = r.f_dq_oe_n;
   assign flash_ce_n = r.f_ce_n;
   assign flash_oe_n = r.f_oe_n;
   assign flash_we_n = r.f_we_n;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [10:0] rec_len;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rec_len <= 11'h000;
      end else if (r.st == fpes_pkg::ST_RECOVER) begin
         rec_len <= rec_len + 11'h001;
      end else begin
         rec_len <= 11'h000;
      end
   end

   recover_wait_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (r.st == fpes_pkg::ST_RECOVER && nx.st != fpes_pkg::ST_RECOVER)
         |-> rec_len == fpes_pkg::RECOVER_CYC - 11'h001)
      else $error("reset recovery wait too short");

   read_no_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (r.op == fpes_pkg::OP_READ && r.st != fpes_pkg::ST_IDLE) |-> flash_we_n)
      else $error("write strobe during plain read");

   unlock_first_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ($fell(flash_we_n) && r.step == 3'h0 && r.op >= fpes_pkg::OP_AUTOSEL &&
       r.op <= fpes_pkg::OP_CHIP_ERASE)
         |-> flash_addr == fpes_pkg::UNLOCK1_ADDR && flash_dq_out == fpes_pkg::UNLOCK1_DATA)
      else $error("first unlock cycle wrong");

   reset_cmd_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ($fell(flash_we_n) && r.op == fpes_pkg::OP_RESET)
         |-> flash_dq_out == fpes_pkg::CMD_RESET && !flash_dq_oe_n)
      else $error("read/reset command not F0");

   erase_add_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ($fell(flash_we_n) && r.op == fpes_pkg::OP_ERASE_ADD)
         |-> !r.rd[fpes_pkg::ERASE_TIMER_BIT])
      else $error("extra erase confirm after timer closed");

   poll_done_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (r.st == fpes_pkg::ST_POLL_EVAL && r.poll_n == 2'h1 &&
       r.rd[fpes_pkg::PRIMARY_TOGGLE_BIT] == r.prev[fpes_pkg::PRIMARY_TOGGLE_BIT])
         |=> r.poll_n == 2'h3 ##[1:40] rsp_valid && !rsp_error)
      else $error("settled toggle did not finish poll");

   strobe_release_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (r.st == fpes_pkg::ST_RD_GAP) |-> flash_oe_n && flash_ce_n && flash_we_n)
      else $error("read strobe not released between reads");

endmodule : fpes_host_ctrl

// ---- fpes_pkg.sv ----
// constants, operation codes and state types for the flash status-polling host controller
package fpes_pkg;

   // ------------------------------------------------------------
   // clock and bus timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int WR_SETUP_NS = 20;
   localparam int WE_PULSE_NS = 40;
   localparam int WR_HOLD_NS = 20;
   localparam int RD_ACCESS_NS = 90;
   localparam int RD_GAP_NS = 20;
   localparam int RECOVER_US = 10;
   // read data pass the pin synchroniser before they are sampled
   localparam int SYNC_LAT = 4;

   localparam logic [10:0] WR_SETUP_CYC = 11'((WR_SETUP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [10:0] WE_PULSE_CYC = 11'((WE_PULSE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [10:0] WR_HOLD_CYC = 11'((WR_HOLD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [10:0] RD_CYC = 11'((RD_ACCESS_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT);
   localparam logic [10:0] RD_GAP_CYC = 11'((RD_GAP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [10:0] RECOVER_CYC = 11'(RECOVER_US * CLK_MHZ);

   // ------------------------------------------------------------
   // word-wide command addresses and data
   // ------------------------------------------------------------
   localparam logic [16:0] UNLOCK1_ADDR = 17'h05555;
   localparam logic [16:0] UNLOCK2_ADDR = 17'h02aaa;
   localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
   localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
   localparam logic [15:0] CMD_RESET = 16'h00f0;
   localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
   localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
   localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
   localparam logic [15:0] CMD_BLOCK_CONFIRM = 16'h0030;
   localparam logic [15:0] CMD_CHIP_CONFIRM = 16'h0010;
   localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
   localparam logic [15:0] CMD_RESUME = 16'h0030;

   // ------------------------------------------------------------
   // status byte fields
   // ------------------------------------------------------------
   localparam int DATA_POLL_BIT = 7;
   localparam int PRIMARY_TOGGLE_BIT = 6;
   localparam int ERROR_FLAG_BIT = 5;
   localparam int ERASE_TIMER_BIT = 3;
   localparam int BLOCK_TOGGLE_BIT = 2;

   // ------------------------------------------------------------
   // user operation codes
   // ------------------------------------------------------------
   localparam logic [3:0] OP_READ = 4'h0;
   localparam logic [3:0] OP_RESET = 4'h1;
   localparam logic [3:0] OP_AUTOSEL = 4'h2;
   localparam logic [3:0] OP_PROGRAM = 4'h3;
   localparam logic [3:0] OP_BLOCK_ERASE = 4'h4;
   localparam logic [3:0] OP_CHIP_ERASE = 4'h5;
   localparam logic [3:0] OP_ERASE_ADD = 4'h6;
   localparam logic [3:0] OP_SUSPEND = 4'h7;
   localparam logic [3:0] OP_RESUME = 4'h8;
   localparam logic [3:0] OP_POLL = 4'h9;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic wr;
      logic [16:0] a;
      logic [15:0] d;
   } fpes_step_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_NEXT, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
      ST_RD_ACT, ST_RD_GAP, ST_POLL_EVAL, ST_RECOVER, ST_RESP
   } fpes_state_t;

   typedef struct packed {
      fpes_state_t st;
      logic [3:0] op;
      logic [2:0] step;
      logic [10:0] cnt;
      logic [16:0] addr_q;
      logic [15:0] wdata_q;
      logic [15:0] rd;
      logic [7:0] prev;
      logic [1:0] poll_n;
      logic in_poll;
      logic err_pend;
      logic busy;
      logic cmd_ready;
      logic rsp_valid;
      logic rsp_error;
      logic [15:0] rsp_rdata;
      logic [16:0] f_addr;
      logic [15:0] f_dq;
      logic f_dq_oe_n;
      logic f_ce_n;
      logic f_oe_n;
      logic f_we_n;
   } fpes_regs_t;

endpackage : fpes_pkg

// ---- fpes_pin_sync.sv ----
// three-stage synchroniser for the flash data pins
module fpes_pin_sync #(
   parameter int WIDTH = 16
) (
   input wire logic ref_clk, // system clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic [WIDTH-1:0] pin, // raw pin levels
   output logic [WIDTH-1:0] q // settled value
);

   logic [WIDTH-1:0] ff1;
   logic [WIDTH-1:0] ff2;
   logic [WIDTH-1:0] ff3;

   // a bit changes once the second and third stages agree
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ff1 <= '0;
         ff2 <= '0;
         ff3 <= '0;
         q <= '0;
      end else begin
         ff1 <= pin;
         ff2 <= ff1;
         ff3 <= ff2;
         for (int i = 0; i < WIDTH; i++) begin
            if (ff2[i] == ff3[i]) begin
               q[i] <= ff3[i];
            end
         end
      end
   end

endmodule : fpes_pin_sync

// ---- fpes_flash_model.sv ----
// behavioural flash device answering the host controller's bus cycles
module fpes_flash_model #(
   parameter logic [15:0] MAN_ID = 16'h00a5, // arbitrary identifier value
   parameter logic [15:0] DEV_ID = 16'h005a, // arbitrary identifier value
   parameter logic [4:0] PROT_BLK = 5'h1f, // the protected block
   parameter int BUSY_READS = 4 // status reads per busy phase
) (
   input wire logic [16:0] addr, // address pins
   input wire logic [15:0] dq, // data lines
   input wire logic ce_n, // chip enable
   input wire logic oe_n, // output enable
   input wire logic we_n, // write enable
   output logic [15:0] dq_drv // value put on the data lines
);
   // --------------------------------------------
   // modes: 0 array, 1 ident, 2 program, 3 timer, 4 erase, 5 suspended
   // --------------------------------------------
   logic [15:0] mem [64];
   logic [15:0] rv = 16'h0000;
   logic [15:0] pd = 16'h0000;
   logic [2:0] stage = 3'h0;
   logic [2:0] mode = 3'h0;
   logic tog = 1'b0;
   logic err = 1'b0;
   logic [4:0] eblk = 5'h00;
   logic keep = 1'b0;
   int left = 0;
   wire logic rd_n = ce_n | oe_n;
   initial foreach (mem[i]) mem[i] = 16'hffff;
   always @(posedge we_n) begin
      if (!ce_n && mode == 3'h3 && dq[7:0] == 8'h30) begin
         left = BUSY_READS;
         keep = keep & (addr[16:12] == PROT_BLK);
      end else if (!ce_n && mode == 3'h4 && dq[7:0] == 8'hb0) begin
         mode = 3'h5;
      end else if (!ce_n && mode == 3'h5 && dq[7:0] == 8'h30) begin
         mode = 3'h4;
      end else if (!ce_n && (mode < 3'h2 || err)) begin
         // the data cycle of a program is data even when it looks like a command
         if (stage == 3'h3) begin
            err = |(dq & ~mem[addr[5:0]]);
            mem[addr[5:0]] = mem[addr[5:0]] & dq;
            pd = dq;
            left = BUSY_READS;
            mode = 3'h2;
            stage = 3'h0;
         end else if (dq[7:0] == 8'hf0) begin
            mode = 3'h0;
            stage = 3'h0;
            err = 1'b0;
         end else if (stage[1:0] == 2'h0 && {addr[14:0], dq[7:0]} == {15'h5555, 8'haa}) begin
            stage = stage + 3'h1;
         end else if (stage[1:0] == 2'h1 && {addr[14:0], dq[7:0]} == {15'h2aaa, 8'h55}) begin
            stage = stage + 3'h1;
         end else if (stage == 3'h2 && dq[7:0] == 8'h90) begin
            mode = 3'h1;
            stage = 3'h0;
         end else if (stage == 3'h2 && dq[7:0] == 8'ha0) begin
            stage = 3'h3;
         end else if (stage == 3'h2 && dq[7:0] == 8'h80) begin
            stage = 3'h4;
         end else if (stage == 3'h6 && (dq[7:0] == 8'h30 || dq[7:0] == 8'h10)) begin
            mode = 3'h3;
            left = BUSY_READS;
            stage = 3'h0;
            eblk = addr[16:12];
            keep = dq[7:0] == 8'h30 && addr[16:12] == PROT_BLK;
         end else begin
            mode = 3'h0;
            stage = 3'h0;
         end
      end
   end
   always @(negedge rd_n) begin
      tog = ~tog;
      case (mode)
         3'h0: rv = mem[addr[5:0]];
         3'h1: rv = addr[1] ? {15'h0000, addr[16:12] == PROT_BLK} : (addr[0] ? DEV_ID : MAN_ID);
         3'h2: rv = {8'h00, ~pd[7], tog, err, 5'h04};
         3'h5: begin
            // suspended block holds bit 6 steady while bit 2 toggles, other blocks read the array
            if (addr[16:12] == eblk) rv = {8'h00, 2'h3, err, 1'b0, 1'b1, tog, 2'h0};
            else rv = mem[addr[5:0]];
         end
         default: rv = {8'h00, 1'b0, tog, err, 1'b0, mode == 3'h4, tog, 2'h0};
      endcase
      if (mode > 3'h1 && mode < 3'h5 && !err) begin
         left = left - 1;
         if (left == 0 && mode == 3'h3) begin
            mode = 3'h4;
            left = BUSY_READS;
         end else if (left == 0) begin
            if (mode == 3'h4 && !keep) foreach (mem[i]) mem[i] = 16'hffff;
            mode = 3'h0;
         end
      end
   end
   // released lines show the inverse of the last value
   assign dq_drv = rd_n ? ~rv : rv;
endmodule : fpes_flash_model

// ---- fpes_host_ctrl_tb.sv ----
// self-checking bench for the flash host controller
module fpes_host_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] MAN_ID = 16'h00a5; // arbitrary identifier value
   localparam logic [15:0] DEV_ID = 16'h005a; // arbitrary identifier value
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic [3:0] cmd_op = 4'h0;
   logic [16:0] cmd_addr = 17'h00000;
   logic [15:0] cmd_wdata = 16'h0000;
   logic cmd_ready, rsp_valid, rsp_error, dq_oe_n, ce_n, oe_n, we_n;
   logic [15:0] rsp_rdata, dq_out, dq_drv;
   logic [16:0] f_addr;
   wire logic [15:0] dq_wire = dq_oe_n ? dq_drv : dq_out;
   logic [16:0] ids_a [4] = '{17'h00000, 17'h00001, 17'h1f002, 17'h00002};
   logic [15:0] ids_d [4] = '{MAN_ID, DEV_ID, 16'h0001, 16'h0000};
   int bad_count = 0;
   int checks = 0;
   int cyc;
   fpes_host_ctrl i_fpes_host_ctrl (.ref_clk(ref_clk), .arst_n(arst_n),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
      .rsp_rdata(rsp_rdata), .flash_addr(f_addr), .flash_dq_out(dq_out),
      .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_wire), .flash_ce_n(ce_n),
      .flash_oe_n(oe_n), .flash_we_n(we_n));
   fpes_flash_model #(.MAN_ID(MAN_ID), .DEV_ID(DEV_ID)) i_fpes_flash_model (.addr(f_addr),
      .dq(dq_wire), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_drv(dq_drv));
   // --------------------------------------------
   // tasks
   // --------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk
   task automatic op(input logic [3:0] o, input logic [16:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      cmd_op <= o;
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_valid <= 1'b1;
      do @(posedge ref_clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      cyc = 0;
      do begin
         @(posedge ref_clk);
         cyc = cyc + 1;
      end while (rsp_valid !== 1'b1 && cyc < 4000);
      if (cyc >= 4000) bad_count = bad_count + 1;
   endtask : op
   task automatic results();
      $display("comparisons %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   // --------------------------------------------
   // clock, watchdog and tests
   // --------------------------------------------
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      #400us;
      bad_count = bad_count + 1;
      results();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      op(4'h3, 17'h00005, 16'h1234);
      chk({15'h0000, rsp_error}, 16'h0000);
      chk(rsp_rdata, 16'h1234);
      op(4'h0, 17'h00005, 16'h0000);
      chk(rsp_rdata, 16'h1234);
      op(4'h2, 17'h00000, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         op(4'h0, ids_a[i], 16'h0000);
         chk(rsp_rdata, ids_d[i]);
      end
      op(4'h1, 17'h00000, 16'h0000);
      op(4'h3, 17'h00005, 16'hffff);
      chk({15'h0000, rsp_error}, 16'h0001);
      op(4'h1, 17'h00000, 16'h0000);
      chk({15'h0000, cyc >= int'(fpes_pkg::RECOVER_CYC)}, 16'h0001);
      op(4'h3, 17'h00006, 16'h00f0);
      chk(rsp_rdata, 16'h00f0);
      chk({15'h0000, rsp_error}, 16'h0000);
      op(4'h5, 17'h00000, 16'h0000);
      chk(16'({rsp_error, rsp_rdata[7]}), 16'h0001);
      op(4'h0, 17'h00006, 16'h0000);
      chk(rsp_rdata, 16'hffff);
      op(4'h4, 17'h00100, 16'h0000);
      op(4'h6, 17'h00200, 16'h0000);
      chk(16'({rsp_error, rsp_rdata[3]}), 16'h0000);
      op(4'h9, 17'h00100, 16'h0000);
      chk(16'({rsp_error, rsp_rdata[7]}), 16'h0001);
      op(4'h6, 17'h00200, 16'h0000);
      chk({15'h0000, rsp_error}, 16'h0001);
      op(4'h0, 17'h00005, 16'h0000);
      chk(rsp_rdata, 16'hffff);
      op(4'h4, 17'h10000, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         op(4'h0, 17'h10000, 16'h0000);
         chk(16'(rsp_rdata[3]), 16'h0000);
      end
      op(4'h7, 17'h10000, 16'h0000);
      chk(16'({rsp_error, rsp_rdata[7:6]}), 16'h0003);
      op(4'h0, 17'h00005, 16'h0000);
      chk(rsp_rdata, 16'hffff);
      op(4'h8, 17'h10000, 16'h0000);
      op(4'h9, 17'h10000, 16'h0000);
      chk(16'({rsp_error, rsp_rdata[7]}), 16'h0001);
      op(4'hc, 17'h00000, 16'h0000);
      chk({15'h0000, rsp_error}, 16'h0001);
      results();
   end
endmodule : fpes_host_ctrl_tb
